// ---- common/asfih_pkg.sv ----
// Constants and types of the set-features and idle command handler
// Behaviour
// - Identify returns the fixed advanced timing word 0492H.
// - Bits 2-0 give highest advanced PIO mode: 0 legacy, 1 mode 5, 2 mode 6.
// - Bits 5-3 give highest advanced multiword DMA: 0 legacy, 1 mode 3, 2 mode 4.
// - Bits 8-6 give selected advanced PIO mode, same encoding.
// - Bits 11-9 give selected advanced DMA mode; bits 15-12 reserved.
// - Opcode EFH carries feature code and a configuration value in sector count.
// - Feature 01H forces 8-bit data, no IOCS16; 81H restores 16-bit.
// - 02H enables, 82H disables write cache; disable flushes before completion.
// - Feature 03H: type in upper five bits, mode in low three bits.
// - Decode PIO default, IORDY off, PIO flow, multiword DMA, Ultra DMA; else reserved.
// - Exactly one PIO mode always selected; changed by set-features, and set to default by software reset unless 66H.
// - 55H disables read look-ahead, power-up default; AAH enables it.
// - 66H keeps settings over software reset; CCH makes software reset restore defaults again.
// - 09H enables, 89H disables extended power operations.
// - Features 69H, 96H and 97H are accepted as no-operations.
// - Idle opcode 97H or E3H: busy, enter idle, clear busy, interrupt.
// - Non-zero idle count is power-down timer in 5 ms units; enable auto power-down.
// - Zero idle count enables auto power-down with three 5 ms units.
`default_nettype none

package asfih_pkg;

    // Register byte addresses
    localparam logic [4:0] A_CMD   = 5'h00;
    localparam logic [4:0] A_STAT  = 5'h04;
    localparam logic [4:0] A_CFG   = 5'h08;
    localparam logic [4:0] A_IDENT = 5'h0C;
    localparam logic [4:0] A_TMR   = 5'h10;

    // Status write bits
    localparam int W_INTCLR = 0;
    localparam int W_SRST   = 1;

    // Opcodes
    localparam logic [7:0] OP_SETF   = 8'hEF;
    localparam logic [7:0] OP_IDLE_A = 8'h97;
    localparam logic [7:0] OP_IDLE_B = 8'hE3;

    // Feature codes
    localparam logic [7:0] F_8B_ON  = 8'h01;
    localparam logic [7:0] F_WC_ON  = 8'h02;
    localparam logic [7:0] F_XFER   = 8'h03;
    localparam logic [7:0] F_EP_ON  = 8'h09;
    localparam logic [7:0] F_LA_OFF = 8'h55;
    localparam logic [7:0] F_KEEP   = 8'h66;
    localparam logic [7:0] F_NOP_A  = 8'h69;
    localparam logic [7:0] F_8B_OFF = 8'h81;
    localparam logic [7:0] F_WC_OFF = 8'h82;
    localparam logic [7:0] F_EP_OFF = 8'h89;
    localparam logic [7:0] F_NOP_B  = 8'h96;
    localparam logic [7:0] F_OLD    = 8'h97;
    localparam logic [7:0] F_LA_ON  = 8'hAA;
    localparam logic [7:0] F_DEFS   = 8'hCC;

    // Transfer types and highest modes
    localparam logic [4:0] T_PIO_DEF = 5'h00;
    localparam logic [4:0] T_PIO_FC  = 5'h01;
    localparam logic [4:0] T_MDMA    = 5'h04;
    localparam logic [4:0] T_UDMA    = 5'h08;
    localparam logic [2:0] PIO_MAX   = 3'h6;
    localparam logic [2:0] MDMA_MAX  = 3'h4;
    localparam logic [2:0] UDMA_MAX  = 3'h4;

    // Advanced timing word fields
    localparam logic [2:0] ID_PIO_SUP  = 3'h2;
    localparam logic [2:0] ID_MDMA_SUP = 3'h2;
    localparam logic [2:0] ID_PIO_SEL  = 3'h2;
    localparam logic [2:0] ID_MDMA_SEL = 3'h2;
    localparam logic [3:0] ID_RSVD     = 4'h0;
    localparam logic [15:0] ID_WORD =
        {ID_RSVD, ID_MDMA_SEL, ID_PIO_SEL, ID_MDMA_SUP, ID_PIO_SUP};

    // Power-down time base
    localparam int         UNIT_MS      = 5;
    localparam int         CLK_KHZ      = 100000;
    localparam int         UNIT_CYC_DEF = UNIT_MS * CLK_KHZ;
    localparam logic [7:0] IDLE_DEF_UNITS = 8'h03;

    typedef enum logic [1:0] {S_IDLE, S_EXEC, S_FLUSH, S_DONE} asfih_fsm_t;

    typedef struct packed {
        logic       iordy_off;
        logic [2:0] udma;
        logic       udma_on;
        logic [2:0] mdma;
        logic       mdma_on;
        logic [2:0] pio;
        logic       keep_cfg;
        logic       extpwr;
        logic       lookahead;
        logic       wcache;
        logic       xfer_8bit;
    } asfih_cfg_t;

    typedef struct packed {
        logic apd_en;
        logic pdn;
        logic idle;
        logic intrq;
        logic abort;
        logic busy;
    } asfih_stat_t;

    typedef struct packed {
        asfih_fsm_t  st;
        asfih_cfg_t  cfg;
        asfih_stat_t stat;
        logic        flush;
        logic [7:0]  opc;
        logic [7:0]  feat;
        logic [7:0]  scnt;
        logic [7:0]  units;
        logic [7:0]  tmr;
        logic [19:0] div;
        logic        run;
        logic        wrq;
        logic [31:0] rdata;
    } asfih_st_t;

    localparam asfih_cfg_t CFG_DEF = 17'h00000;

    localparam asfih_st_t ST_RST = '{
        st: S_IDLE, cfg: CFG_DEF, stat: 6'h00, flush: 1'b0,
        opc: 8'h00, feat: 8'h00, scnt: 8'h00, units: 8'h00,
        tmr: 8'h00, div: 20'h00000, run: 1'b0, wrq: 1'b1,
        rdata: 32'h00000000};

endpackage

`default_nettype wire

// ---- hdl/asfih_top.sv ----
// Set-features and idle command handler with Avalon-MM register access
`timescale 1ns/1ns
`default_nettype none

module asfih_top #(
    parameter int UNIT_CYC = asfih_pkg::UNIT_CYC_DEF
) (
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output var  logic [31:0] avs_readdata,
    output var  logic        avs_waitrequest,
    input  wire logic        flush_done,
    output var  logic        flush_req,
    output var  logic        xfer_8bit,
    output var  logic        wcache_en,
    output var  logic        lookahead_en,
    output var  logic        extpwr_en,
    output var  logic        host_intrq,
    output var  logic        busy,
    output var  logic        power_down
);
    import asfih_pkg::*;

    // ************************************************************
    // Decode helpers
    // ************************************************************

    // Feature code listed as supported
    function automatic logic feat_known(input logic [7:0] f);
        case (f)
            F_8B_ON, F_WC_ON, F_XFER, F_EP_ON, F_LA_OFF, F_KEEP,
            F_NOP_A, F_8B_OFF, F_WC_OFF, F_EP_OFF, F_NOP_B,
            F_OLD, F_LA_ON, F_DEFS:
                feat_known = 1'b1;
            default:
                feat_known = 1'b0;
        endcase
    endfunction

    // Idle opcode in either form
    function automatic logic is_idle(input logic [7:0] op);
        is_idle = (op == OP_IDLE_A) || (op == OP_IDLE_B);
    endfunction

    // ************************************************************
    // State
    // ************************************************************

    asfih_st_t q;
    asfih_st_t n;

    logic bus_wr;
    logic bus_acc;

    // Request completes in the cycle waitrequest is low
    assign bus_acc = (avs_read || avs_write) && !q.wrq;
    assign bus_wr  = avs_write && !q.wrq;

    // ************************************************************
    // Next-state logic
    // ************************************************************

    // Bus slave, command launch, executor and power-down timer
    always_comb
    begin
        n = q;

        // One wait cycle, then answer
        if (!q.wrq)
        begin
            n.wrq = 1'b1;
        end
        else if (avs_read || avs_write)
        begin
            n.wrq = 1'b0;
            case (avs_address)
                A_CMD:   n.rdata = {8'h00, q.scnt, q.feat, q.opc};
                A_STAT:  n.rdata = 32'(q.stat);
                A_CFG:   n.rdata = 32'(q.cfg);
                A_IDENT: n.rdata = 32'(ID_WORD);
                A_TMR:   n.rdata = {16'h0000, q.units, q.tmr};
                default: n.rdata = 32'h00000000;
            endcase
        end

        // Command block write launches a command
        if (bus_wr && avs_address == A_CMD && avs_byteenable[0] && !q.stat.busy)
        begin
            n.opc = avs_writedata[7:0];
            if (avs_byteenable[1])
            begin
                n.feat = avs_writedata[15:8];
            end
            if (avs_byteenable[2])
            begin
                n.scnt = avs_writedata[23:16];
            end
            n.st         = S_EXEC;
            n.stat.busy  = 1'b1;
            n.stat.abort = 1'b0;
            n.stat.intrq = 1'b0;
            n.stat.pdn   = 1'b0;
            n.stat.idle  = 1'b0;
            n.run        = 1'b0;
        end

        // Status write: interrupt clear and software reset
        if (bus_wr && avs_address == A_STAT && avs_byteenable[0])
        begin
            if (avs_writedata[W_INTCLR])
            begin
                n.stat.intrq = 1'b0;
            end
            if (avs_writedata[W_SRST] && !q.stat.busy)
            begin
                n.stat.abort = 1'b0;
                if (!q.cfg.keep_cfg)
                begin
                    n.cfg = CFG_DEF;
                end
            end
        end

        // Power-down timer in 5 ms ticks; expiry beats a launch clear
        if (q.run)
        begin
            if (q.div == 20'(UNIT_CYC - 1))
            begin
                n.div = 20'h00000;
                if (q.tmr <= 8'h01)
                begin
                    n.tmr      = 8'h00;
                    n.run      = 1'b0;
                    n.stat.pdn = 1'b1;
                end
                else
                begin
                    n.tmr = q.tmr - 8'h01;
                end
            end
            else
            begin
                n.div = q.div + 20'h00001;
            end
        end

        // Command executor
        case (q.st)
            S_IDLE:
            begin
                // Keep the launch above, which moves on to EXEC
            end
            S_EXEC:
            begin
                n.st = S_DONE;
                if (q.opc == OP_SETF && !feat_known(q.feat))
                begin
                    n.stat.abort = 1'b1;
                end
                else if (q.opc == OP_SETF)
                begin
                    case (q.feat)
                        F_8B_ON:  n.cfg.xfer_8bit = 1'b1;
                        F_8B_OFF: n.cfg.xfer_8bit = 1'b0;
                        F_WC_ON:  n.cfg.wcache = 1'b1;
                        F_WC_OFF:
                        begin
                            n.cfg.wcache = 1'b0;
                            n.flush      = 1'b1;
                            n.st         = S_FLUSH;
                        end
                        F_EP_ON:  n.cfg.extpwr = 1'b1;
                        F_EP_OFF: n.cfg.extpwr = 1'b0;
                        F_LA_OFF: n.cfg.lookahead = 1'b0;
                        F_LA_ON:  n.cfg.lookahead = 1'b1;
                        F_KEEP:   n.cfg.keep_cfg = 1'b1;
                        F_DEFS:   n.cfg.keep_cfg = 1'b0;
                        F_XFER:
                        begin
                            // Type in bits 7-3, mode in bits 2-0
                            case (q.scnt[7:3])
                                T_PIO_DEF:
                                begin
                                    if (q.scnt[2:1] == 2'h0)
                                    begin
                                        n.cfg.pio       = 3'h0;
                                        n.cfg.iordy_off = q.scnt[0];
                                    end
                                    else
                                    begin
                                        n.stat.abort = 1'b1;
                                    end
                                end
                                T_PIO_FC:
                                begin
                                    if (q.scnt[2:0] <= PIO_MAX)
                                    begin
                                        n.cfg.pio       = q.scnt[2:0];
                                        n.cfg.iordy_off = 1'b0;
                                    end
                                    else
                                    begin
                                        n.stat.abort = 1'b1;
                                    end
                                end
                                T_MDMA:
                                begin
                                    if (q.scnt[2:0] <= MDMA_MAX)
                                    begin
                                        n.cfg.mdma    = q.scnt[2:0];
                                        n.cfg.mdma_on = 1'b1;
                                        n.cfg.udma_on = 1'b0;
                                    end
                                    else
                                    begin
                                        n.stat.abort = 1'b1;
                                    end
                                end
                                T_UDMA:
                                begin
                                    if (q.scnt[2:0] <= UDMA_MAX)
                                    begin
                                        n.cfg.udma    = q.scnt[2:0];
                                        n.cfg.udma_on = 1'b1;
                                        n.cfg.mdma_on = 1'b0;
                                    end
                                    else
                                    begin
                                        n.stat.abort = 1'b1;
                                    end
                                end
                                default: n.stat.abort = 1'b1;
                            endcase
                        end
                        default:
                        begin
                            n.stat.abort = 1'b0;
                        end
                    endcase
                end
                else if (is_idle(q.opc))
                begin
                    n.stat.idle   = 1'b1;
                    n.stat.apd_en = 1'b1;
                    if (q.scnt == 8'h00)
                    begin
                        n.units = IDLE_DEF_UNITS;
                    end
                    else
                    begin
                        n.units = q.scnt;
                    end
                end
                else
                begin
                    n.stat.abort = 1'b1;
                end
            end
            S_FLUSH:
            begin
                // Completion waits for cached data to reach flash
                if (flush_done)
                begin
                    n.flush = 1'b0;
                    n.st    = S_DONE;
                end
            end
            S_DONE:
            begin
                n.st         = S_IDLE;
                n.stat.busy  = 1'b0;
                n.stat.intrq = 1'b1;
                if (q.stat.apd_en)
                begin
                    n.run = 1'b1;
                    n.div = 20'h00000;
                    n.tmr = n.units;
                end
            end
            default:
            begin
                n.st = S_IDLE;
            end
        endcase
    end

    // ************************************************************
    // State register
    // ************************************************************

    // Whole state in one register
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            q <= ST_RST;
        end
        else
        begin
            q <= n;
        end
    end

    // Outputs straight from state flops
    assign avs_readdata    = q.rdata;
    assign avs_waitrequest = q.wrq;
    assign flush_req       = q.flush;
    assign xfer_8bit       = q.cfg.xfer_8bit;
    assign wcache_en       = q.cfg.wcache;
    assign lookahead_en    = q.cfg.lookahead;
    assign extpwr_en       = q.cfg.extpwr;
    assign host_intrq      = q.stat.intrq;
    assign busy            = q.stat.busy;
    assign power_down      = q.stat.pdn;

    // ************************************************************
    // Assertions
    // ************************************************************

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    logic exec_setf;
    logic exec_idle;

    // Executor decode points
    assign exec_setf = (q.st == S_EXEC) && (q.opc == OP_SETF);
    assign exec_idle = (q.st == S_EXEC) && is_idle(q.opc);

    a_bus_answer:
        assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not answered after one wait cycle");

    a_ident_word:
        assert property ($fell(avs_waitrequest) && avs_read && avs_address == A_IDENT
                         |-> avs_readdata == 32'h00000492)
        else $error("advanced timing word wrong");

    a_narrow_data:
        assert property (exec_setf && q.feat == F_8B_ON |=> xfer_8bit ##1 xfer_8bit)
        else $error("8-bit transfer not selected");

    a_flush_first:
        assert property (exec_setf && q.feat == F_WC_OFF
                         |=> flush_req && !wcache_en && busy && !host_intrq)
        else $error("cache disable did not start flush before completion");

    a_look_ahead:
        assert property (exec_setf && q.feat == F_LA_ON |=> lookahead_en)
        else $error("read look-ahead not enabled");

    a_idle_seq:
        assert property (exec_idle |=> busy ##1 (!busy && host_intrq && q.stat.idle))
        else $error("idle command sequence wrong");

    a_idle_default:
        assert property (exec_idle && q.scnt == 8'h00 |=> ##1 q.run && q.tmr == 8'h03)
        else $error("zero idle count not loaded as three units");

    a_bad_keep:
        assert property (exec_setf && !feat_known(q.feat)
                         |=> $stable(q.cfg) && q.stat.abort)
        else $error("unknown feature changed settings or was not aborted");

    a_cfg_source:
        assert property (!$stable(q.cfg) |-> $past(q.st) == S_EXEC
                         || $past(bus_wr && avs_address == A_STAT))
        else $error("settings changed outside feature command or reset");

    a_timer_restart:
        assert property (bus_wr && avs_address == A_CMD && avs_byteenable[0] && !busy
                         && !(q.run && q.tmr <= 8'h01 && q.div == 20'(UNIT_CYC - 1))
                         |=> !q.run && !power_down)
        else $error("new command did not restart power-down timer");

    c_idle_done:
        cover property (exec_idle ##2 host_intrq);
    c_flush_done:
        cover property (flush_req ##[1:20] !flush_req);
    c_power_down:
        cover property ($rose(power_down));
    c_abort:
        cover property ($rose(q.stat.abort));

endmodule // asfih_top

`default_nettype wire

// ---- tb/asfih_flush_model.sv ----
// Flash side stand-in that answers cache flush requests
`timescale 1ns/1ns
`default_nettype none

module asfih_flush_model (
    input  wire logic       core_clk,
    input  wire logic       flush_req,
    input  wire logic [3:0] dly,
    output var  logic       flush_done
);
    logic [3:0] cnt_q;

    // Finish a flush dly+1 cycles after the request rises, drop one cycle after the request
    always_ff @(posedge core_clk)
    begin
        cnt_q      <= flush_req ? cnt_q + 4'h1 : 4'h0;
        flush_done <= flush_req && (cnt_q >= dly);
    end
endmodule // asfih_flush_model

`default_nettype wire

// ---- tb/asfih_top_bench.sv ----
// Self-checking bench of the set-features and idle handler
`timescale 1ns/1ns
`default_nettype none

module asfih_top_bench;
    import asfih_pkg::*;
    localparam int UC = 10;
    logic        core_clk, sys_rst, avs_read, avs_write, avs_waitrequest;
    logic        flush_done, flush_req, xfer_8bit, wcache_en, lookahead_en;
    logic        extpwr_en, host_intrq, busy, power_down;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0]  dly;
    logic [63:0] expq [$];
    logic [63:0] e;
    int          num_errors, n_checks, seed, k, n, bc;
    logic [7:0]  ft [13] = '{8'h01, 8'h02, 8'h09, 8'hAA, 8'h66, 8'h69, 8'h96,
                             8'h97, 8'h81, 8'h82, 8'h89, 8'h55, 8'hCC};
    logic [4:0]  fc [13] = '{5'h01, 5'h03, 5'h0B, 5'h0F, 5'h1F, 5'h1F, 5'h1F,
                             5'h1F, 5'h1E, 5'h1C, 5'h14, 5'h10, 5'h00};
    logic [7:0]  sc [10] = '{8'h01, 8'h0E, 8'h0F, 8'h24, 8'h25, 8'h43, 8'h45,
                             8'h10, 8'h02, 8'h00};
    logic [31:0] mk [10] = '{32'h10000, 32'hE0, 32'hE0, 32'hF00, 32'hF00,
                             32'hF000, 32'hF000, 32'hE0, 32'hE0, 32'hE0};
    logic [31:0] vl [10] = '{32'h10000, 32'hC0, 32'hC0, 32'h900, 32'h900,
                             32'h7000, 32'h7000, 32'hC0, 32'hC0, 32'h00};
    logic        ab [10] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};

    asfih_top #(.UNIT_CYC(UC)) i_dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .flush_done(flush_done),
        .flush_req(flush_req), .xfer_8bit(xfer_8bit), .wcache_en(wcache_en),
        .lookahead_en(lookahead_en), .extpwr_en(extpwr_en),
        .host_intrq(host_intrq), .busy(busy), .power_down(power_down));

    asfih_flush_model i_flash (
        .core_clk(core_clk), .flush_req(flush_req), .dly(dly),
        .flush_done(flush_done));

    // ********************
    // Tasks
    // ********************
    task automatic chk(input logic [31:0] got, input logic [31:0] m,
                       input logic [31:0] exp, input string s);
        n_checks++;
        if ((got & m) !== (exp & m))
        begin
            num_errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, s, got, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int w;
        @(posedge core_clk);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_writedata <= d;
        w = 0;
        do
        begin
            @(posedge core_clk);
            w++;
        end
        while (avs_waitrequest !== 1'b0 && w < 20);
        chk(w < 20, 1, 1, "bus answer");
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] v);
        expq.push_back({m, v});
        bus(1'b0, a, 32'h0);
    endtask

    task automatic cmd(input logic [7:0] op, input logic [7:0] f, input logic [7:0] s);
        bus(1'b1, A_CMD, {8'h00, s, f, op});
        bc = 0;
        do
        begin
            @(posedge core_clk);
            bc++;
        end
        while (busy !== 1'b0 && bc < 200);
        chk(bc < 200, 1, 1, "command end");
    endtask

    task automatic pdwait(input int u);
        int w;
        w = 0;
        while (power_down !== 1'b1 && w < 2000)
        begin
            @(posedge core_clk);
            w++;
        end
        chk(w >= u - 3 && w <= u + 3, 1, 1, "power-down time");
    endtask

    task automatic end_sim;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Clock
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Read monitor takes the oldest note off the queue
    always @(posedge core_clk)
    begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
        begin
            e = expq.pop_front();
            chk(avs_readdata, e[63:32], e[31:0], "read data");
        end
    end

    // Watchdog
    initial
    begin
        #300000;
        num_errors++;
        end_sim();
    end

    // Main sequence
    initial
    begin
        sys_rst = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 5'h00;
        avs_writedata = 32'h0;
        seed = 62232;
        dly = 4'($random(seed));
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd(A_CFG, 32'hFFFFFFFF, 32'h0);
        rd(A_STAT, 32'hFFFFFFFF, 32'h0);
        rd(A_IDENT, 32'hFFFFFFFF, 32'h492);
        rd(5'h14, 32'hFFFFFFFF, 32'h0);
        $display("test reset values done");
        for (k = 0; k < 13; k++)
        begin
            cmd(OP_SETF, ft[k], 8'($random(seed)));
            rd(A_CFG, 32'h1F, 32'(fc[k]));
            rd(A_STAT, 32'h7, 32'h4);
            chk({host_intrq, extpwr_en, lookahead_en, wcache_en, xfer_8bit},
                32'h1F, {1'b1, fc[k][3:0]}, "pins");
            if (ft[k] == F_WC_OFF)
                chk(bc > dly && flush_req === 1'b0, 1, 1, "flush wait");
        end
        $display("test feature codes done");
        cmd(OP_SETF, F_WC_ON, 8'h00);
        cmd(OP_SETF, F_KEEP, 8'h00);
        bus(1'b1, A_STAT, 32'h2);
        rd(A_CFG, 32'h1F, 32'h12);
        cmd(OP_SETF, F_DEFS, 8'h00);
        bus(1'b1, A_STAT, 32'h1);
        rd(A_STAT, 32'h4, 32'h0);
        bus(1'b1, A_STAT, 32'h2);
        rd(A_CFG, 32'h1F, 32'h0);
        $display("test soft reset done");
        for (k = 0; k < 10; k++)
        begin
            cmd(OP_SETF, F_XFER, sc[k]);
            rd(A_CFG, mk[k], vl[k]);
            rd(A_STAT, 32'h7, {29'h0, 1'b1, ab[k], 1'b0});
        end
        cmd(OP_SETF, 8'h05, 8'h00);
        rd(A_STAT, 32'h7, 32'h6);
        cmd(8'h20, 8'h00, 8'h00);
        rd(A_STAT, 32'h7, 32'h6);
        $display("test transfer modes done");
        cmd(OP_IDLE_B, 8'h00, 8'h00);
        pdwait(3 * UC);
        rd(A_TMR, 32'hFF00, 32'h0300);
        rd(A_STAT, 32'h3F, 32'h3C);
        n = 1 + ($random(seed) & 3);
        cmd(OP_IDLE_A, 8'h00, n[7:0]);
        chk(power_down, 1, 0, "power-down cleared");
        pdwait(n * UC);
        rd(A_TMR, 32'hFF00, {16'h0, n[7:0], 8'h00});
        $display("test idle timer done");
        repeat (4) @(posedge core_clk);
        end_sim();
    end
endmodule // asfih_top_bench

`default_nettype wire
